// [logic/mslc_lock_ctrl.sv]
// lock byte store with software and programming-interface access gating
`timescale 1ns/1ns
`default_nettype none
`include "mslc_params.svh"
module mslc_lock_ctrl (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // software lock byte write (store instruction path)
  input wire logic sw_wr,
  input wire logic [7:0] sw_wdata,
  // programming interface lock byte write
  input wire logic pi_lock_wr,
  input wire logic [7:0] pi_wdata,
  // chip erase command
  input wire logic chip_erase,
  // lock byte readback
  output logic [7:0] memory_lock_byte,
  // software section access
  input wire logic sw_store_req,
  input wire logic sw_load_req,
  input wire logic sw_from_boot,
  input wire logic sw_in_table,
  output logic sw_grant,
  output logic sw_deny,
  // interrupt gating
  input wire logic vectors_in_boot,
  input wire logic exec_in_app,
  output logic irq_disable,
  // programming interface access
  input wire logic pi_req,
  input wire mslc_pkg::mslc_pa_kind_t pi_kind,
  output logic pi_grant,
  output logic pi_deny,
  // test interface and on-chip debug
  input wire logic test_interface_req,
  input wire logic on_chip_debug_req,
  output logic debug_block
);
  mslc_lock_if lk ();
  logic [7:0] lock_q;
  logic app_blk;
  logic app_rl;
  logic tbl_blk;
  logic tbl_rl;
  mslc_pkg::mslc_state_t state;
  mslc_pkg::mslc_field_t ext;
  logic pi_refuse;
  logic lock_wr_refuse;

  // only moves toward stricter: bitwise and keeps existing zeros
  function automatic logic [1:0] stricter(input logic [1:0] cur, input logic [1:0] req);
    stricter = cur & req;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // lock byte storage
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lock_q <= `MSLC_RESET_BYTE;
    end else if (chip_erase) begin
      lock_q <= `MSLC_RESET_BYTE;
    end else if (pi_lock_wr && !lock_wr_refuse) begin
      lock_q[`MSLC_UPPER_HI:`MSLC_UPPER_LO] <= lock_q[`MSLC_UPPER_HI:`MSLC_UPPER_LO];
      lock_q[`MSLC_APP_HI:`MSLC_APP_LO] <= stricter(lock_q[`MSLC_APP_HI:`MSLC_APP_LO],
        pi_wdata[`MSLC_APP_HI:`MSLC_APP_LO]);
      lock_q[`MSLC_TBL_HI:`MSLC_TBL_LO] <= stricter(lock_q[`MSLC_TBL_HI:`MSLC_TBL_LO],
        pi_wdata[`MSLC_TBL_HI:`MSLC_TBL_LO]);
      lock_q[`MSLC_EXT_HI:`MSLC_EXT_LO] <= stricter(lock_q[`MSLC_EXT_HI:`MSLC_EXT_LO],
        pi_wdata[`MSLC_EXT_HI:`MSLC_EXT_LO]);
    end else if (sw_wr) begin
      // software cannot touch the programming lock field
      lock_q[`MSLC_APP_HI:`MSLC_APP_LO] <= stricter(lock_q[`MSLC_APP_HI:`MSLC_APP_LO],
        sw_wdata[`MSLC_APP_HI:`MSLC_APP_LO]);
      lock_q[`MSLC_TBL_HI:`MSLC_TBL_LO] <= stricter(lock_q[`MSLC_TBL_HI:`MSLC_TBL_LO],
        sw_wdata[`MSLC_TBL_HI:`MSLC_TBL_LO]);
    end
  end

  // erase state is observable one cycle for tracking only
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state <= mslc_pkg::mslc_st_idle;
    end else begin
      case (state)
        mslc_pkg::mslc_st_idle: begin
          if (chip_erase) state <= mslc_pkg::mslc_st_erase;
        end
        mslc_pkg::mslc_st_erase: begin
          state <= mslc_pkg::mslc_st_idle;
        end
        default: begin
          state <= mslc_pkg::mslc_st_idle;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      memory_lock_byte <= `MSLC_RESET_BYTE;
    end else begin
      memory_lock_byte <= lock_q;
    end
  end

  assign lk.lock_byte = lock_q;

  ////////////////////////////////////////////////////////////////////////////////
  // software section checks
  mslc_section_check u_app (
    .field(lk.lock_byte[`MSLC_APP_HI:`MSLC_APP_LO]),
    .store_req(sw_store_req & ~sw_in_table),
    .load_req(sw_load_req & ~sw_in_table),
    .from_boot(sw_from_boot),
    .blocked(app_blk),
    .read_locked(app_rl)
  );
  mslc_section_check u_tbl (
    .field(lk.lock_byte[`MSLC_TBL_HI:`MSLC_TBL_LO]),
    .store_req(sw_store_req & sw_in_table),
    .load_req(sw_load_req & sw_in_table),
    .from_boot(sw_from_boot),
    .blocked(tbl_blk),
    .read_locked(tbl_rl)
  );

  // programming lock field plays no part in software access
  always_comb begin
    sw_deny = app_blk | tbl_blk;
    sw_grant = (sw_store_req | sw_load_req) & ~sw_deny;
    irq_disable = vectors_in_boot & exec_in_app & (app_rl | tbl_rl);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // programming interface and debug checks
  always_comb begin
    ext = lk.lock_byte[`MSLC_EXT_HI:`MSLC_EXT_LO];
    // lock byte writes judged on the field alone, whatever the access kind
    lock_wr_refuse = ~ext[`MSLC_RD_BLOCK_BIT];
    pi_refuse = 1'b0;
    if (ext[`MSLC_RD_BLOCK_BIT] == 1'b0) begin
      pi_refuse = 1'b1;
    end else if (ext[`MSLC_WR_BLOCK_BIT] == 1'b0) begin
      pi_refuse = (pi_kind == mslc_pkg::mslc_pa_mem_write)
        | (pi_kind == mslc_pkg::mslc_pa_fuse_write);
    end
    if (pi_kind == mslc_pkg::mslc_pa_lock_write && ext[`MSLC_RD_BLOCK_BIT] != 1'b0) begin
      pi_refuse = 1'b0;
    end
    if (!pi_req) pi_refuse = 1'b0;
    pi_deny = pi_req & pi_refuse;
    pi_grant = pi_req & ~pi_refuse;
    debug_block = (test_interface_req | on_chip_debug_req) & ~(&ext);
  end
endmodule : mslc_lock_ctrl
`default_nettype wire

// [logic/mslc_lock_if.sv]
// lock fields carried from the lock store to the access checkers
`timescale 1ns/1ns
`default_nettype none
interface mslc_lock_if;
  logic [7:0] lock_byte;
  modport store (output lock_byte);
  modport check (input lock_byte);
endinterface : mslc_lock_if
`default_nettype wire

// [logic/mslc_params.svh]
// constants of the memory section lock control block
`ifndef MSLC_PARAMS_SVH
`define MSLC_PARAMS_SVH
`define MSLC_RESET_BYTE 8'hFF
`define MSLC_APP_HI 5
`define MSLC_APP_LO 4
`define MSLC_TBL_HI 3
`define MSLC_TBL_LO 2
`define MSLC_EXT_HI 1
`define MSLC_EXT_LO 0
`define MSLC_UPPER_HI 7
`define MSLC_UPPER_LO 6
`define MSLC_WR_BLOCK_BIT 0
`define MSLC_RD_BLOCK_BIT 1
`endif

// [logic/mslc_pkg.sv]
// types of the memory section lock control block
package mslc_pkg;
  typedef logic [1:0] mslc_field_t;
  typedef enum logic [1:0] {
    mslc_read_write_lock_setting = 2'h0,
    mslc_read_lock_setting = 2'h1,
    mslc_write_lock_setting = 2'h2,
    mslc_no_restriction_setting = 2'h3
  } mslc_lock_t;
  // programming interface access kinds
  typedef enum logic [2:0] {
    mslc_pa_mem_write = 3'h0,
    mslc_pa_mem_read = 3'h1,
    mslc_pa_fuse_write = 3'h3,
    mslc_pa_fuse_read = 3'h2,
    mslc_pa_lock_write = 3'h6,
    mslc_pa_lock_read = 3'h7
  } mslc_pa_kind_t;
  typedef enum logic [1:0] {
    mslc_st_idle = 2'h0,
    mslc_st_erase = 2'h1
  } mslc_state_t;
endpackage : mslc_pkg

// [logic/mslc_section_check.sv]
// decodes one software section lock field against a store or load access
`timescale 1ns/1ns
`default_nettype none
`include "mslc_params.svh"
module mslc_section_check (
  // lock field
  input wire logic [1:0] field,
  // access
  input wire logic store_req,
  input wire logic load_req,
  input wire logic from_boot,
  // verdict
  output logic blocked,
  output logic read_locked
);
  // 0 in a bit means that restriction is active
  always_comb begin
    read_locked = ~field[`MSLC_RD_BLOCK_BIT];
    blocked = (store_req & ~field[`MSLC_WR_BLOCK_BIT])
      | (load_req & from_boot & ~field[`MSLC_RD_BLOCK_BIT]);
  end
endmodule : mslc_section_check
`default_nettype wire

// [test/mslc_lock_ctrl_props.sv]
// assertions on the lock byte store ports
`timescale 1ns/1ns
`default_nettype none
module mslc_lock_ctrl_props (
  // watched ports
  input wire logic clk,
  rstn,
  sw_wr,
  pi_lock_wr,
  chip_erase,
  sw_store_req,
  sw_load_req,
  sw_from_boot,
  sw_in_table,
  sw_grant,
  sw_deny,
  vectors_in_boot,
  exec_in_app,
  irq_disable,
  pi_req,
  pi_deny,
  test_interface_req,
  debug_block,
  input wire logic [7:0] memory_lock_byte,
  input wire mslc_pkg::mslc_pa_kind_t pi_kind
);
  // readback lags the store by one cycle, so it shows what a verdict used
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  property p_app_wr;
    sw_store_req && !sw_in_table |=> memory_lock_byte[4] != $past(sw_deny);
  endproperty
  a_app_wr: assert property (p_app_wr) else $error("app store verdict");
  property p_sw_free;
    sw_load_req && !sw_from_boot && !sw_store_req |-> sw_grant;
  endproperty
  a_sw_free: assert property (p_sw_free) else $error("app load refused");
  property p_erase;
    chip_erase |=> ##1 memory_lock_byte == 8'hff;
  endproperty
  a_erase: assert property (p_erase) else $error("erase not clearing");
  property p_stricter;
    !$past(chip_erase, 2) |-> (memory_lock_byte & ~$past(memory_lock_byte)) == 8'h00;
  endproperty
  a_stricter: assert property (p_stricter) else $error("lock loosened");
  property p_sw_ext;
    sw_wr && !pi_lock_wr && !chip_erase |=> ##1
      memory_lock_byte[1:0] == $past(memory_lock_byte[1:0]);
  endproperty
  a_sw_ext: assert property (p_sw_ext) else $error("software hit ext");
  property p_pi_wr;
    pi_req && pi_kind == mslc_pkg::mslc_pa_fuse_write |=>
      $past(pi_deny) == (memory_lock_byte[1:0] != 2'h3);
  endproperty
  a_pi_wr: assert property (p_pi_wr) else $error("fuse write verdict");
  property p_pi_rd;
    pi_req && pi_kind == mslc_pkg::mslc_pa_mem_read |=> $past(pi_deny) == !memory_lock_byte[1];
  endproperty
  a_pi_rd: assert property (p_pi_rd) else $error("mem read verdict");
  property p_dbg;
    test_interface_req |=> $past(debug_block) == (memory_lock_byte[1:0] != 2'h3);
  endproperty
  a_dbg: assert property (p_dbg) else $error("debug block verdict");
  property p_irq;
    vectors_in_boot && exec_in_app |=>
      $past(irq_disable) == !(memory_lock_byte[5] && memory_lock_byte[3]);
  endproperty
  a_irq: assert property (p_irq) else $error("irq gating");
  c_erase: cover property (chip_erase);
  c_pi_deny: cover property (pi_req && pi_deny);
  c_sw_deny: cover property (sw_deny);
endmodule // mslc_lock_ctrl_props
bind mslc_lock_ctrl mslc_lock_ctrl_props i_props (.*);
`default_nettype wire

// [test/mslc_lock_ctrl_tb_top.sv]
// self-checking bench of the lock byte store
`timescale 1ns/1ns
`default_nettype none
module mslc_lock_ctrl_tb_top;
  logic clk, rstn, sw_wr, pi_lock_wr, chip_erase, sw_store_req, sw_load_req, go;
  logic sw_from_boot, sw_in_table, sw_grant, sw_deny, vectors_in_boot, exec_in_app;
  logic irq_disable, pi_req, pi_grant, pi_deny, test_interface_req, on_chip_debug_req;
  logic debug_block;
  logic [7:0] sw_wdata, pi_wdata, go_data, memory_lock_byte;
  mslc_pkg::mslc_pa_kind_t pi_kind;
  int n_fail = 0;
  int cmp_count = 0;
  mslc_lock_ctrl i_mslc_lock_ctrl (.*);
  mslc_prog_model i_mslc_prog_model (.*);
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic sw_put(input logic [7:0] d);
    @(posedge clk);
    sw_wr <= 1'b1;
    sw_wdata <= d;
    @(posedge clk);
    sw_wr <= 1'b0;
  endtask
  task automatic pi_put(input logic [7:0] d);
    @(posedge clk);
    go <= 1'b1;
    go_data <= d;
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wrap_up;
    $display("compares %0d failures %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  task automatic t_sw;
    sw_put(8'hef);
    @(posedge clk);
    sw_store_req <= 1'b1;
    #10;
    chk("store deny", 1, sw_deny);
    chk("lock byte", 8'hef, memory_lock_byte);
    @(posedge clk);
    sw_store_req <= 1'b0;
    sw_load_req <= 1'b1;
    sw_from_boot <= 1'b1;
    #10;
    chk("boot load grant", 1, sw_grant);
    sw_put(8'hff);
    sw_put(8'hc0);
    @(posedge clk);
    vectors_in_boot <= 1'b1;
    exec_in_app <= 1'b1;
    #10;
    chk("boot load deny", 1, sw_deny);
    chk("irq off", 1, irq_disable);
    chk("lock byte", 8'hc3, memory_lock_byte);
    @(posedge clk);
    sw_from_boot <= 1'b0;
    #10;
    chk("app load grant", 1, sw_grant);
    $display("test sw done");
  endtask
  task automatic t_pi;
    pi_put(8'hfe);
    pi_req <= 1'b1;
    pi_kind <= mslc_pkg::mslc_pa_fuse_write;
    test_interface_req <= 1'b1;
    #10;
    chk("fuse write deny", 1, pi_deny);
    chk("debug block", 1, debug_block);
    @(posedge clk);
    pi_kind <= mslc_pkg::mslc_pa_mem_read;
    #10;
    chk("mem read deny", 0, pi_deny);
    chk("mem read grant", 1, pi_grant);
    pi_put(8'hfc);
    #10;
    chk("mem read deny", 1, pi_deny);
    $display("test pi done");
  endtask
  task automatic t_erase;
    @(posedge clk);
    chip_erase <= 1'b1;
    @(posedge clk);
    chip_erase <= 1'b0;
    #10;
    chk("debug block", 0, debug_block);
    @(posedge clk);
    #10;
    chk("lock byte", 8'hff, memory_lock_byte);
    $display("test erase done");
  endtask
  initial begin
    {rstn, sw_wr, chip_erase, sw_store_req, sw_load_req, go, sw_from_boot} = '0;
    {sw_in_table, vectors_in_boot, exec_in_app, pi_req, test_interface_req} = '0;
    {on_chip_debug_req, sw_wdata, go_data} = '0;
    pi_kind = mslc_pkg::mslc_pa_mem_write;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    t_sw();
    t_pi();
    t_erase();
    wrap_up();
  end
  initial begin
    #1000000;
    n_fail++;
    wrap_up();
  end
endmodule // mslc_lock_ctrl_tb_top
`default_nettype wire

// [test/mslc_prog_model.sv]
// external programmer issuing lock byte writes
`timescale 1ns/1ns
`default_nettype none
module mslc_prog_model (
  // clock
  input wire logic clk,
  // request from bench
  input wire logic go,
  input wire logic [7:0] go_data,
  // programming interface
  output logic pi_lock_wr,
  output logic [7:0] pi_wdata
);
  initial pi_lock_wr = 1'b0;
  initial pi_wdata = 8'h00;
  // data toggles once released, so a stale byte never looks valid
  always @(posedge clk) begin
    pi_lock_wr <= go;
    pi_wdata <= go ? go_data : ~pi_wdata;
  end
endmodule // mslc_prog_model
`default_nettype wire
